// file: sfd_pkg.sv
package sfd_pkg;

  localparam int SFD_NUM_CH = 8;
  localparam int SFD_NUM_DUAL = 4;
  localparam int SFD_DUAL_BASE = 4;
  localparam int SFD_TH_W = 8;
  localparam int SFD_HYST_W = 5;
  localparam int SFD_FILT_W = 7;
  localparam int SFD_MODE_W = 2;

  localparam int SFD_CLK_FREQ_HZ = 125000000;
  localparam int SFD_HZ_PER_MHZ = 1000000;
  localparam int SFD_GF_MAX_US = 100;
  localparam int SFD_GF_MAX_CYCLES =
    SFD_GF_MAX_US * (SFD_CLK_FREQ_HZ / SFD_HZ_PER_MHZ);

  localparam logic [SFD_TH_W-1:0] SFD_TH_FULL = 8'hff;
  localparam logic [SFD_TH_W-1:0] SFD_TH_ZERO = 8'h00;
  localparam logic [SFD_TH_W-1:0] SFD_TH_RST = 8'h00;
  localparam logic [SFD_HYST_W-1:0] SFD_HYST_RST = 5'h00;

  typedef enum logic [SFD_MODE_W-1:0] {
    SFD_MODE_UV = 2'b00,
    SFD_MODE_OV = 2'b01,
    SFD_MODE_WINDOW = 2'b10,
    SFD_MODE_OFF = 2'b11
  } sfd_mode_e;

endpackage

// file: sfd_top.sv
// Summary of operation
// - Eight inputs; four dedicated, four dual-function.
// - Dual input is analog or digital; in digital mode its detector still warns.
// - Detector flags undervoltage, overvoltage or out-of-window.
// - Each threshold is an 8-bit code.
// - Code N maps to bottom plus N/255 span.
// - Comparisons are evaluated continuously every cycle.
// - Active undervoltage clears above threshold plus hysteresis.
// - Active overvoltage clears below threshold minus hysteresis.
// - Hysteresis is a 5-bit code, one-255th span steps.
// - Comparator result passes a glitch filter stage.
// - Filter timeout programmable up to 100 microseconds.
// - Pulses shorter than the timeout are suppressed.
// - Longer pulses pass, delayed by the timeout.
// - Warnings readable individually and ORed into one.

module sfd_glitch_filter #(
  parameter int CNT_W = 14
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic raw_in,
  input wire logic [CNT_W-1:0] ticks_in,
  output logic filt_out
);
  logic [CNT_W-1:0] cnt_q;
  logic filt_q;

  // The output moves only after the raw level differs for ticks_in edges.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (raw_in == filt_q) begin
      cnt_q <= '0;
    end else if (cnt_q + 1'b1 >= ticks_in) begin
      cnt_q <= '0;
      filt_q <= raw_in;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign filt_out = filt_q;
endmodule // sfd_glitch_filter

module sfd_top
  import sfd_pkg::*;
#(
  parameter int GF_MAX_CYCLES = SFD_GF_MAX_CYCLES,
  parameter int GF_MAX_US = SFD_GF_MAX_US,
  parameter int CNT_W = $clog2(GF_MAX_CYCLES + 1)
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [SFD_NUM_CH*SFD_MODE_W-1:0] mode_in,
  input wire logic [SFD_NUM_CH*SFD_TH_W-1:0] uv_threshold_in,
  input wire logic [SFD_NUM_CH*SFD_TH_W-1:0] ov_threshold_in,
  input wire logic [SFD_NUM_CH*SFD_HYST_W-1:0] hysteresis_in,
  input wire logic [SFD_NUM_CH*SFD_FILT_W-1:0] filter_us_in,
  input wire logic [SFD_NUM_DUAL-1:0] dual_digital_mode_in,
  input wire logic [SFD_NUM_CH-1:0] uv_below_in,
  input wire logic [SFD_NUM_CH-1:0] ov_above_in,
  input wire logic [SFD_NUM_DUAL-1:0] dual_function_input_in,
  output logic [SFD_NUM_CH*SFD_TH_W-1:0] uv_reference_out,
  output logic [SFD_NUM_CH*SFD_TH_W-1:0] ov_reference_out,
  output logic [SFD_NUM_CH-1:0] fault_out,
  output logic [SFD_NUM_DUAL-1:0] warning_out,
  output logic warning_any_out,
  output logic [SFD_NUM_DUAL-1:0] digital_out
);

  localparam int TICKS_PER_US = GF_MAX_CYCLES / GF_MAX_US;
  localparam logic [SFD_FILT_W-1:0] FILT_MAX_US = SFD_FILT_W'(GF_MAX_US);

  // Comparator results and pins are asynchronous to the core clock.
  logic [SFD_NUM_CH-1:0] uv_meta_q, uv_sync_q;
  logic [SFD_NUM_CH-1:0] ov_meta_q, ov_sync_q;
  logic [SFD_NUM_DUAL-1:0] pin_meta_q, pin_sync_q;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      uv_meta_q <= '0;
      uv_sync_q <= '0;
    end else begin
      uv_meta_q <= uv_below_in;
      uv_sync_q <= uv_meta_q;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ov_meta_q <= '0;
      ov_sync_q <= '0;
    end else begin
      ov_meta_q <= ov_above_in;
      ov_sync_q <= ov_meta_q;
    end
  end

  // Pins bounce like comparators, so they get the same flip-flop pair.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= dual_function_input_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Hysteresis state of each comparison and the references fed back.
  logic [SFD_NUM_CH-1:0] uv_hold_q, uv_hold_d;
  logic [SFD_NUM_CH-1:0] ov_hold_q, ov_hold_d;
  logic [SFD_NUM_CH-1:0] raw_fault_q, raw_fault_d;
  logic [SFD_NUM_CH*SFD_TH_W-1:0] uv_ref_q, uv_ref_d;
  logic [SFD_NUM_CH*SFD_TH_W-1:0] ov_ref_q, ov_ref_d;
  logic [CNT_W-1:0] ticks_q [SFD_NUM_CH];
  logic [CNT_W-1:0] ticks_d [SFD_NUM_CH];

  always_comb begin
    logic [SFD_TH_W-1:0] uth;
    logic [SFD_TH_W-1:0] oth;
    logic [SFD_HYST_W-1:0] hy;
    logic [SFD_TH_W:0] usum;
    logic [SFD_FILT_W-1:0] fus;
    sfd_mode_e md;
    uth = '0;
    oth = '0;
    hy = '0;
    usum = '0;
    fus = '0;
    md = SFD_MODE_OFF;
    uv_hold_d = '0;
    ov_hold_d = '0;
    raw_fault_d = '0;
    uv_ref_d = '0;
    ov_ref_d = '0;
    for (int c = 0; c < SFD_NUM_CH; c++) begin
      uth = uv_threshold_in[c*SFD_TH_W +: SFD_TH_W];
      oth = ov_threshold_in[c*SFD_TH_W +: SFD_TH_W];
      hy = hysteresis_in[c*SFD_HYST_W +: SFD_HYST_W];
      md = sfd_mode_e'(mode_in[c*SFD_MODE_W +: SFD_MODE_W]);
      fus = filter_us_in[c*SFD_FILT_W +: SFD_FILT_W];
      if (fus > FILT_MAX_US) begin
        fus = FILT_MAX_US;
      end
      ticks_d[c] = CNT_W'(int'(fus) * TICKS_PER_US);
      // Codes go to the comparator DAC, where code N is bottom+N/255 span.
      usum = {1'b0, uth} + {{(SFD_TH_W + 1 - SFD_HYST_W){1'b0}}, hy};
      if (uv_hold_q[c]) begin
        uv_ref_d[c*SFD_TH_W +: SFD_TH_W] =
          usum[SFD_TH_W] ? SFD_TH_FULL : usum[SFD_TH_W-1:0];
      end else begin
        uv_ref_d[c*SFD_TH_W +: SFD_TH_W] = uth;
      end
      if (ov_hold_q[c]) begin
        ov_ref_d[c*SFD_TH_W +: SFD_TH_W] = (oth < SFD_TH_W'(hy)) ?
          SFD_TH_ZERO : oth - SFD_TH_W'(hy);
      end else begin
        ov_ref_d[c*SFD_TH_W +: SFD_TH_W] = oth;
      end
      case (md)
        SFD_MODE_UV: begin
          uv_hold_d[c] = uv_sync_q[c];
          raw_fault_d[c] = uv_sync_q[c];
        end
        SFD_MODE_OV: begin
          ov_hold_d[c] = ov_sync_q[c];
          raw_fault_d[c] = ov_sync_q[c];
        end
        SFD_MODE_WINDOW: begin
          uv_hold_d[c] = uv_sync_q[c];
          ov_hold_d[c] = ov_sync_q[c];
          raw_fault_d[c] = uv_sync_q[c] | ov_sync_q[c];
        end
        default: begin
          raw_fault_d[c] = 1'b0;
        end
      endcase
    end
  end

  // A hold follows its comparator, so leaving a mode drops its hysteresis.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      uv_hold_q <= '0;
      ov_hold_q <= '0;
    end else begin
      uv_hold_q <= uv_hold_d;
      ov_hold_q <= ov_hold_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      raw_fault_q <= '0;
    end else begin
      raw_fault_q <= raw_fault_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      uv_ref_q <= {SFD_NUM_CH{SFD_TH_RST}};
      ov_ref_q <= {SFD_NUM_CH{SFD_TH_RST}};
    end else begin
      uv_ref_q <= uv_ref_d;
      ov_ref_q <= ov_ref_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int c = 0; c < SFD_NUM_CH; c++) begin
        ticks_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < SFD_NUM_CH; c++) begin
        ticks_q[c] <= ticks_d[c];
      end
    end
  end

  // A zero timeout still costs one edge; the filter never bypasses.
  logic [SFD_NUM_CH-1:0] filt_fault;
  logic [SFD_NUM_DUAL-1:0] filt_pin;

  for (genvar g = 0; g < SFD_NUM_CH; g++) begin : g_ana
    sfd_glitch_filter #(.CNT_W(CNT_W)) u_filt (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .raw_in(raw_fault_q[g]),
      .ticks_in(ticks_q[g]),
      .filt_out(filt_fault[g])
    );
  end

  for (genvar g = 0; g < SFD_NUM_DUAL; g++) begin : g_dig
    sfd_glitch_filter #(.CNT_W(CNT_W)) u_filt (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .raw_in(pin_sync_q[g]),
      .ticks_in(ticks_q[SFD_DUAL_BASE + g]),
      .filt_out(filt_pin[g])
    );
  end

  // A dual input in digital mode turns its detector into a warning.
  logic [SFD_NUM_CH-1:0] fault_q;
  logic [SFD_NUM_DUAL-1:0] warn_q, dig_q;
  logic warn_any_q;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fault_q <= '0;
    end else begin
      fault_q[SFD_DUAL_BASE-1:0] <= filt_fault[SFD_DUAL_BASE-1:0];
      for (int d = 0; d < SFD_NUM_DUAL; d++) begin
        if (dual_digital_mode_in[d]) begin
          fault_q[SFD_DUAL_BASE + d] <= 1'b0;
        end else begin
          fault_q[SFD_DUAL_BASE + d] <= filt_fault[SFD_DUAL_BASE + d];
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      warn_q <= '0;
      dig_q <= '0;
    end else begin
      for (int d = 0; d < SFD_NUM_DUAL; d++) begin
        if (dual_digital_mode_in[d]) begin
          warn_q[d] <= filt_fault[SFD_DUAL_BASE + d];
          dig_q[d] <= filt_pin[d];
        end else begin
          warn_q[d] <= 1'b0;
          dig_q[d] <= 1'b0;
        end
      end
    end
  end

  // Built from the same filtered bits so it never leads the warnings.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      warn_any_q <= 1'b0;
    end else begin
      warn_any_q <= |(filt_fault[SFD_NUM_CH-1:SFD_DUAL_BASE] &
                      dual_digital_mode_in);
    end
  end

  assign uv_reference_out = uv_ref_q;
  assign ov_reference_out = ov_ref_q;
  assign fault_out = fault_q;
  assign warning_out = warn_q;
  assign warning_any_out = warn_any_q;
  assign digital_out = dig_q;

endmodule // sfd_top

// file: sfd_cmp_model.sv
module sfd_cmp_model (
  input wire logic [63:0] level_in,
  input wire logic [63:0] uv_ref_in,
  input wire logic [63:0] ov_ref_in,
  output logic [7:0] uv_below_out,
  output logic [7:0] ov_above_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Analog comparators never sleep, so this is purely combinational.
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      uv_below_out[c] = level_in[8*c+:8] < uv_ref_in[8*c+:8];
      ov_above_out[c] = level_in[8*c+:8] > ov_ref_in[8*c+:8];
    end
  end
endmodule // sfd_cmp_model

// file: sfd_top_props.sv
module sfd_top_props
  import sfd_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [15:0] mode_in,
  input wire logic [63:0] uv_threshold_in,
  input wire logic [63:0] ov_threshold_in,
  input wire logic [39:0] hysteresis_in,
  input wire logic [55:0] filter_us_in,
  input wire logic [3:0] dual_digital_mode_in,
  input wire logic [7:0] uv_below_in,
  input wire logic [7:0] ov_above_in,
  input wire logic [3:0] dual_function_input_in,
  input wire logic [63:0] uv_reference_out,
  input wire logic [63:0] ov_reference_out,
  input wire logic [7:0] fault_out,
  input wire logic [3:0] warning_out,
  input wire logic warning_any_out,
  input wire logic [3:0] digital_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_uv0;
    (mode_in[1:0] == SFD_MODE_UV) [*6];
  endsequence
  sequence s_win1;
    (mode_in[3:2] == SFD_MODE_WINDOW) [*6];
  endsequence
  // Checked five edges back, which holds for any timeout of one tick or more.
  a_uv_rise_cause: assert property (s_uv0 ##0 $rose(fault_out[0]) |->
    $past(uv_below_in[0], 5)) else $error("uv rise early");
  a_uv_fall_cause: assert property (s_uv0 ##0 $fell(fault_out[0]) |->
    !$past(uv_below_in[0], 5)) else $error("uv fall early");
  a_win_rise_or: assert property (s_win1 ##0 $rose(fault_out[1]) |->
    $past(uv_below_in[1] | ov_above_in[1], 5)) else $error("window rise");
  a_ov_ref_idle: assert property (s_uv0 |->
    ov_reference_out[7:0] == $past(ov_threshold_in[7:0]))
    else $error("ov ref moved");
  a_off_quiet: assert property ((mode_in[3:2] == SFD_MODE_OFF &&
    filter_us_in[13:7] == 7'h00) [*6] |-> !fault_out[1])
    else $error("off fault");
  a_analog_quiet: assert property ((!dual_digital_mode_in[0]) [*4] |->
    !(digital_out[0] | warning_out[0])) else $error("analog digital");
  a_digital_no_fault: assert property ((dual_digital_mode_in[0] &&
    filter_us_in[34:28] == 7'h00) [*8] |-> !fault_out[4])
    else $error("digital fault");
  a_warn_merge: assert property (
    warning_any_out == |warning_out) else $error("warning merge");
endmodule // sfd_top_props

bind sfd_top sfd_top_props sfd_top_props_inst (.*);

// file: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] mode = 16'hfcfc;
  logic [63:0] uvt = 64'h0000_0080_0000_0080;
  logic [63:0] ovt = {8{8'hff}};
  logic [63:0] lvl = 64'h8080_8010_8080_80a0;
  logic [39:0] hy = 40'h04;
  logic [55:0] fu = 56'h02;
  logic [3:0] ddm = 4'h0;
  logic [3:0] dpin = 4'h1;
  logic [63:0] uref, oref;
  logic [7:0] ub, oa, flt;
  logic [3:0] warn, dig;
  logic wany;
  int n_errors = 0;
  int checks = 0;
  int u, o, h, l, m, s, p, uh, oh, lp;
  always #4 clk = ~clk;
  sfd_top #(.GF_MAX_CYCLES(200)) sfd_top_inst (
    .core_clk_in(clk), .rst_b_in(rst_b), .mode_in(mode),
    .uv_threshold_in(uvt), .ov_threshold_in(ovt), .hysteresis_in(hy),
    .filter_us_in(fu), .dual_digital_mode_in(ddm), .uv_below_in(ub),
    .ov_above_in(oa), .dual_function_input_in(dpin),
    .uv_reference_out(uref), .ov_reference_out(oref), .fault_out(flt),
    .warning_out(warn), .warning_any_out(wany), .digital_out(dig));
  sfd_cmp_model sfd_cmp_model_inst (.level_in(lvl), .uv_ref_in(uref),
    .ov_ref_in(oref), .uv_below_out(ub), .ov_above_out(oa));
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wn(int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    void'($urandom(32'hd5a0));
    u = $urandom_range(255);
    o = $urandom_range(255);
    h = $urandom_range(31);
    s = u + h > 255 ? 255 : u + h;
    p = o < h ? 0 : o - h;
    uh = 0;
    oh = 0;
    lp = 8'h80;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    uvt[15:8] <= 8'(u);
    ovt[15:8] <= 8'(o);
    hy[9:5] <= 5'(h);
    wn(10);
    // Channel 0 filters four ticks; a three-tick dip must vanish.
    @(posedge clk);
    lvl[7:0] <= 8'h70;
    repeat (3) @(posedge clk);
    lvl[7:0] <= 8'ha0;
    repeat (12) begin
      wn(1);
      chk("fault0", 8'(flt[0]), 8'h00);
    end
    @(posedge clk);
    lvl[7:0] <= 8'h70;
    wn(8);
    chk("fault0", 8'(flt[0]), 8'h00);
    wn(1);
    chk("fault0", 8'(flt[0]), 8'h01);
    chk("uvref0", uref[7:0], 8'h84);
    @(posedge clk);
    lvl[7:0] <= 8'h82;
    wn(20);
    chk("fault0", 8'(flt[0]), 8'h01);
    @(posedge clk);
    lvl[7:0] <= 8'h85;
    wn(20);
    chk("fault0", 8'(flt[0]), 8'h00);
    chk("uvref0", uref[7:0], 8'h80);
    // Channel 1 walks random modes and levels against the hold model.
    repeat (40) begin
      m = $urandom_range(3);
      l = $urandom_range(255);
      // The new mode first judges the old level, then the level moves.
      @(posedge clk);
      mode[3:2] <= 2'(m);
      uh = (m == 0 || m == 2) && lp < (uh ? s : u);
      oh = (m == 1 || m == 2) && lp > (oh ? p : o);
      wn(6);
      @(posedge clk);
      lvl[15:8] <= 8'(l);
      uh = (m == 0 || m == 2) && l < (uh ? s : u);
      oh = (m == 1 || m == 2) && l > (oh ? p : o);
      lp = l;
      wn(12);
      chk("fault1", 8'(flt[1]), 8'(uh | oh));
      chk("uvref1", uref[15:8], 8'(uh ? s : u));
      chk("ovref1", oref[15:8], 8'(oh ? p : o));
    end
    // Channel 2 asks for 127 us and must be held to 100 us, 200 ticks.
    @(posedge clk);
    mode[5:4] <= 2'b00;
    uvt[23:16] <= 8'h90;
    fu[20:14] <= 7'h7f;
    wn(204);
    chk("fault2", 8'(flt[2]), 8'h00);
    wn(2);
    chk("fault2", 8'(flt[2]), 8'h01);
    chk("fault4", 8'(flt[4]), 8'h01);
    chk("digital", 8'(dig), 8'h00);
    @(posedge clk);
    ddm <= 4'h1;
    wn(20);
    chk("fault4", 8'(flt[4]), 8'h00);
    chk("digital", 8'(dig), 8'h01);
    chk("warning", 8'(warn), 8'h01);
    chk("warnany", 8'(wany), 8'h01);
    summarize();
  end
  // The sequence needs about a thousand cycles; five times that is a hang.
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule // tb
